// file: cdgcr_pkg.sv
/*
  Constants, field layouts and carrier types for the capture DMA and
  port control register block.
  Assumes a 12-bit byte offset and 32-bit data on the register port.
*/
package cdgcr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFF_STATUS   = 12'h100;
  localparam logic [11:0] OFF_MASK     = 12'h104;
  localparam logic [11:0] OFF_CTL      = 12'h10C;
  localparam logic [11:0] OFF_START    = 12'h114;
  localparam logic [11:0] OFF_OE       = 12'h118;
  localparam logic [11:0] OFF_INSEL    = 12'h11C;
  localparam logic [11:0] OFF_PC       = 12'h120;
  localparam logic [11:0] OFF_DATA_LO  = 12'h200;
  localparam logic [11:0] OFF_DATA_HI  = 12'h2FF;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [23:0] RST_MASK     = 24'h000000;
  localparam logic [15:0] RST_CTL      = 16'h0000;
  localparam logic [31:0] RST_START    = 32'h00000000;
  localparam logic [31:0] RST_PC       = 32'h00000000;
  localparam logic [23:0] RST_OE       = 24'h000000;
  localparam logic [23:0] RST_INSEL    = 24'h000000;
  localparam logic [23:0] RST_DATA     = 24'h000000;
  localparam logic [15:0] CTL_WR_MASK  = 16'hFCFF;
  localparam int          IRQ_SRC_W    = 23;
  localparam int          COMPAT_BIT   = 23;
  localparam int          PORT_IRQ_BIT = 9;
  localparam int          PORT_W       = 24;
  localparam logic [31:0] PC_STEP      = 32'h00000004;

  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_PIX_OUT = 2'h1;
  localparam logic [1:0]  MODE_PIX_IN  = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       port_irq_edge_select;
    logic       port_irq_invert;
    logic       strobe_edge_select;
    logic [1:0] port_function_mode;
    logic       port_clock_direction;
    logic [1:0] reserved;
    logic [1:0] planar_trigger_second_third;
    logic [1:0] planar_trigger_first;
    logic [1:0] packed_trigger_level;
    logic       dma_engine_enable;
    logic       fifo_enable;
  } cdgcr_ctl_t;

  typedef struct packed {
    logic       engine_enable;
    logic       fifo_enable;
    logic       fifo_flush;
    logic [5:0] trig_first;
    logic [5:0] trig_second_third;
    logic [5:0] trig_packed;
  } cdgcr_dma_t;

  // Trigger code to double-word count: 4, 8, 16, 32
  function automatic logic [5:0] cdgcr_trig_dwords(input logic [1:0] code);
    return 6'h04 << code;
  endfunction : cdgcr_trig_dwords

endpackage : cdgcr_pkg

// file: cdgcr_sync3.sv
/*
  Three-stage synchroniser for pin inputs.
  Assumes inputs asynchronous to core_clk_i; a bit changes at the output
  only once the second and third stages agree.
*/
`timescale 1ns/1ps
module cdgcr_sync3 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // Agreement filter swallows a single-stage glitch
  always_comb begin
    out_nxt = (s2_r ~^ s3_r) & s3_r | (s2_r ^ s3_r) & out_r;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;

  sync_agree_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ((out_r ^ $past(out_r)) & $past(s2_r ^ s3_r)) == '0)
    else $error("sync output moved without stage agreement");

endmodule : cdgcr_sync3

// file: cdgcr_edge_capture.sv
/*
  Captures the port inputs on the programmed edge of the write strobe.
  Assumes strobe and data already synchronised with equal latency.
*/
`timescale 1ns/1ps
module cdgcr_edge_capture #(
  parameter int W = 24
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         strobe_i,
  input  wire logic         edge_sel_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] data_o
);

  logic         strobe_d_r;
  logic         hit;
  logic [W-1:0] cap_r;
  logic [W-1:0] cap_nxt;

  always_comb begin
    hit     = edge_sel_i ? (strobe_d_r & ~strobe_i) : (~strobe_d_r & strobe_i);
    cap_nxt = hit ? data_i : cap_r;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_d_r <= 1'b0;
      cap_r      <= '0;
    end else begin
      strobe_d_r <= strobe_i;
      cap_r      <= cap_nxt;
    end
  end

  assign data_o = cap_r;

  capture_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (strobe_d_r == strobe_i) |=> $stable(cap_r))
    else $error("captured port data changed without a strobe edge");

endmodule : cdgcr_edge_capture

// file: cdgcr_regs.sv
/*
  Control registers of the capture DMA engine and general-purpose port:
  interrupt mask and request, DMA start address and program counter,
  FIFO control and trigger points, port enables, capture and data.
  Assumes a simple register port (one-cycle write/read strobes), pending
  status bits supplied by the interrupt status register beside it.
*/
`timescale 1ns/1ps

// Operation
// - Mask bits 22:0 pass matching pending status to interrupt; reset zero.
// - Unmasking an already pending status raises the interrupt immediately.
// - Interrupt is a level, held while any unmasked status stays pending.
// - Mask bit 23 selects host chipset compatibility; resets to zero.
// - Read-only register returns DMA program counter, may lead execution.
// - Enable rising edge loads start address into program counter.
// - Control bit 1 enables DMA instruction processing; clear stops it.
// - Control bit 0 enables pixel FIFO; zero flushes and holds it reset.
// - Planar trigger fields code 4, 8, 16 or 32 double words.
// - Packed trigger field codes total double words before a burst.
// - Mode field: normal port, pixel output, pixel input, reserved.
// - Clock direction bit drives pixel clock out or takes it in.
// - Invert bit flips external interrupt input right after its buffer.
// - Strobe edge bit: zero captures on rising, one on falling.
// - Each output-enable bit turns on its pin driver; reset zero.
// - Input-select bit picks direct pin or captured value for reads.
// - Data window writes drive outputs, reads return input buffer.
// - Status bits clear by writing one; zero leaves them unchanged.
// - Port interrupt status sets on programmed edge or level of pin.
// - Parity error during instruction fetch clears the DMA enable.
module cdgcr_regs
  import cdgcr_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic [22:0]       int_status_i,
  output logic                   irq_o,
  output logic                   port_irq_status_o,
  output logic                   host_chipset_compat_o,
  input  wire logic              dma_parity_err_i,
  input  wire logic              dma_fetch_advance_i,
  output cdgcr_dma_t             dma_ctl_o,
  output logic      [31:0]       dma_program_counter_o,
  output logic      [1:0]        port_function_mode_o,
  input  wire logic [23:0]       port_pin_data_i,
  output logic      [23:0]       port_pin_data_o,
  output logic      [23:0]       port_pin_data_oe_n_o,
  input  wire logic              port_write_strobe_pin_i,
  input  wire logic              external_irq_pin_i,
  input  wire logic              single_rate_pixel_clock_i,
  output logic                   port_clock_pin_o,
  output logic                   port_clock_pin_oe_n_o,
  output logic                   pixel_clock_from_pin_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [23:0] mask_r;
  logic [23:0] mask_nxt;
  cdgcr_ctl_t  ctl_r;
  cdgcr_ctl_t  ctl_nxt;
  logic [31:0] start_r;
  logic [31:0] start_nxt;
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [23:0] oe_r;
  logic [23:0] oe_nxt;
  logic [23:0] insel_r;
  logic [23:0] insel_nxt;
  logic [23:0] data_r;
  logic [23:0] data_nxt;
  logic        pirq_r;
  logic        pirq_nxt;
  logic        irq_src_d_r;
  logic        irq_src_d_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  logic [23:0] pin_sync;
  logic [23:0] pin_cap;
  logic        strobe_sync;
  logic        irq_pin_sync;
  logic        irq_src;
  logic        pirq_set;
  logic        in_window;
  logic [23:0] port_read;
  logic [22:0] pending;
  logic        en_rise;

  // ---------------------------------------------------------------
  // Pin synchronisers and strobe capture
  // ---------------------------------------------------------------
  cdgcr_sync3 #(
    .W (PORT_W + 2)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({port_write_strobe_pin_i, external_irq_pin_i, port_pin_data_i}),
    .sync_o     ({strobe_sync, irq_pin_sync, pin_sync})
  );

  cdgcr_edge_capture #(
    .W (PORT_W)
  ) u_cap (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .strobe_i   (strobe_sync),
    .edge_sel_i (ctl_r.strobe_edge_select),
    .data_i     (pin_sync),
    .data_o     (pin_cap)
  );

  // ---------------------------------------------------------------
  // Register writes and hardware updates
  // ---------------------------------------------------------------
  always_comb begin
    mask_nxt      = mask_r;
    ctl_nxt       = ctl_r;
    start_nxt     = start_r;
    oe_nxt        = oe_r;
    insel_nxt     = insel_r;
    data_nxt      = data_r;
    in_window     = (reg_addr_i >= OFF_DATA_LO) && (reg_addr_i <= OFF_DATA_HI);
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_MASK) begin
        mask_nxt = reg_wdata_i[23:0];
      end
      if (reg_addr_i == OFF_CTL) begin
        // Reserved bits never stored, so they always read zero
        ctl_nxt = cdgcr_ctl_t'(reg_wdata_i[15:0] & CTL_WR_MASK);
      end
      if (reg_addr_i == OFF_START) begin
        start_nxt = reg_wdata_i;
      end
      if (reg_addr_i == OFF_OE) begin
        oe_nxt = reg_wdata_i[23:0];
      end
      if (reg_addr_i == OFF_INSEL) begin
        insel_nxt = reg_wdata_i[23:0];
      end
      if (in_window) begin
        data_nxt = reg_wdata_i[23:0];
      end
    end
    // Parity stop overrides a software set in the same cycle
    if (dma_parity_err_i) begin
      ctl_nxt.dma_engine_enable = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // DMA program counter
  // ---------------------------------------------------------------
  always_comb begin
    en_rise = ctl_nxt.dma_engine_enable & ~ctl_r.dma_engine_enable;
    pc_nxt  = pc_r;
    if (en_rise) begin
      pc_nxt = start_nxt;
    end else if (ctl_r.dma_engine_enable && dma_fetch_advance_i) begin
      // Advances on prefetch, so it may lead execution
      pc_nxt = pc_r + PC_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Port interrupt and interrupt request
  // ---------------------------------------------------------------
  always_comb begin
    irq_src       = irq_pin_sync ^ ctl_r.port_irq_invert;
    irq_src_d_nxt = irq_src;
    pirq_set      = ctl_r.port_irq_edge_select ? (irq_src & ~irq_src_d_r)
                                               : irq_src;
    pirq_nxt      = pirq_r;
    if (reg_wr_i && reg_addr_i == OFF_STATUS && reg_wdata_i[PORT_IRQ_BIT]) begin
      pirq_nxt = 1'b0;
    end
    if (pirq_set) begin
      pirq_nxt = 1'b1;
    end
    pending                = int_status_i;
    pending[PORT_IRQ_BIT]  = int_status_i[PORT_IRQ_BIT] | pirq_r;
    // Level request, recomputed every cycle from mask and pending
    irq_nxt = |(pending & mask_nxt[IRQ_SRC_W-1:0]);
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    port_read = (insel_r & pin_cap) | (~insel_r & pin_sync);
    rdata_nxt = 32'h00000000;
    if (reg_rd_i) begin
      unique case (1'b1)
        reg_addr_i == OFF_MASK:  rdata_nxt = {8'h00, mask_r};
        reg_addr_i == OFF_CTL:   rdata_nxt = {16'h0000, ctl_r};
        reg_addr_i == OFF_START: rdata_nxt = start_r;
        reg_addr_i == OFF_OE:    rdata_nxt = {8'h00, oe_r};
        reg_addr_i == OFF_INSEL: rdata_nxt = {8'h00, insel_r};
        reg_addr_i == OFF_PC:    rdata_nxt = pc_r;
        in_window: begin
          // Only meaningful in normal port mode; other modes read zero
          if (ctl_r.port_function_mode == MODE_NORMAL) begin
            rdata_nxt = {8'h00, port_read};
          end
        end
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r      <= RST_MASK;
      ctl_r       <= cdgcr_ctl_t'(RST_CTL);
      start_r     <= RST_START;
      pc_r        <= RST_PC;
      oe_r        <= RST_OE;
      insel_r     <= RST_INSEL;
      data_r      <= RST_DATA;
      pirq_r      <= 1'b0;
      irq_src_d_r <= 1'b0;
      irq_r       <= 1'b0;
      rdata_r     <= 32'h00000000;
    end else begin
      mask_r      <= mask_nxt;
      ctl_r       <= ctl_nxt;
      start_r     <= start_nxt;
      pc_r        <= pc_nxt;
      oe_r        <= oe_nxt;
      insel_r     <= insel_nxt;
      data_r      <= data_nxt;
      pirq_r      <= pirq_nxt;
      irq_src_d_r <= irq_src_d_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o           = rdata_r;
  assign irq_o                 = irq_r;
  assign port_irq_status_o     = pirq_r;
  assign host_chipset_compat_o = mask_r[COMPAT_BIT];
  assign dma_program_counter_o = pc_r;
  assign port_function_mode_o  = ctl_r.port_function_mode;
  assign port_pin_data_o       = data_r;
  assign port_pin_data_oe_n_o  = ~oe_r;

  assign dma_ctl_o.engine_enable     = ctl_r.dma_engine_enable;
  assign dma_ctl_o.fifo_enable       = ctl_r.fifo_enable;
  assign dma_ctl_o.fifo_flush        = ~ctl_r.fifo_enable;
  assign dma_ctl_o.trig_first        = cdgcr_trig_dwords(ctl_r.planar_trigger_first);
  assign dma_ctl_o.trig_second_third =
    cdgcr_trig_dwords(ctl_r.planar_trigger_second_third);
  assign dma_ctl_o.trig_packed       = cdgcr_trig_dwords(ctl_r.packed_trigger_level);

  // Clock routing only; the pin clock itself is muxed outside this block
  assign port_clock_pin_o       = single_rate_pixel_clock_i & ctl_r.port_clock_direction;
  assign port_clock_pin_oe_n_o  = ~ctl_r.port_clock_direction;
  assign pixel_clock_from_pin_o = ~ctl_r.port_clock_direction &&
                                  ctl_r.port_function_mode == MODE_PIX_IN;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  unmask_raise_a: assert property (
    reg_wr_i && reg_addr_i == OFF_MASK && |(pending & reg_wdata_i[22:0])
    |=> irq_o)
    else $error("unmasking a pending source did not raise the request");

  irq_level_a: assert property (
    (|(pending & mask_r[22:0])) && !(reg_wr_i && reg_addr_i == OFF_MASK) |=> irq_o)
    else $error("request dropped while an unmasked source was pending");

  pc_load_a: assert property (
    $rose(ctl_r.dma_engine_enable) |-> pc_r == $past(start_nxt))
    else $error("program counter not loaded on enable rise");

  pc_hold_a: assert property (
    !ctl_r.dma_engine_enable ##1 !ctl_r.dma_engine_enable |-> $stable(pc_r))
    else $error("program counter moved while engine disabled");

  parity_stop_a: assert property (
    dma_parity_err_i |=> !dma_ctl_o.engine_enable)
    else $error("parity error did not stop the engine");

  pirq_set_a: assert property (
    pirq_set |=> port_irq_status_o)
    else $error("port interrupt event lost against a clear");

  pin_drive_a: assert property (
    reg_wr_i && reg_addr_i == OFF_OE
    |=> port_pin_data_oe_n_o == ~$past(reg_wdata_i[23:0]))
    else $error("output enables did not follow the write");

  pc_read_a: assert property (
    reg_rd_i && reg_addr_i == OFF_PC |=> reg_rdata_o == $past(pc_r))
    else $error("program counter read returned wrong value");

  reserved_zero_a: assert property (
    reg_rd_i && reg_addr_i == OFF_CTL |=> reg_rdata_o[31:16] == 16'h0000
    && reg_rdata_o[9:8] == 2'h0)
    else $error("reserved control bits read nonzero");

endmodule : cdgcr_regs

// file: cdgcr_pin_model.sv
/*
  Behavioural far-side logic on the general-purpose port pins.
  Assumes the bench supplies what the outside world drives on each pin.
*/
`timescale 1ns/1ps
module cdgcr_pin_model (
  input  wire logic [23:0] ext_data_i,
  input  wire logic [23:0] dut_data_i,
  input  wire logic [23:0] dut_oe_n_i,
  output logic      [23:0] pin_o
);
  // ---------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------
  // Driven pins follow the device, released pins the outside world
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_o[i] = dut_oe_n_i[i] ? ext_data_i[i] : dut_data_i[i];
    end
  end
endmodule : cdgcr_pin_model

// file: testbench.sv
/*
  Self-checking bench for the capture DMA and port control registers.
  Assumes the pin model resolves the port pins from both drivers.
*/
`timescale 1ns/1ps
module testbench;
  import cdgcr_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, perr = 1'b0, adv = 1'b0;
  logic        strb = 1'b0, xirq = 1'b0, pclk = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rv, seed = 32'h7B9D, a, d;
  logic [22:0] stat = 23'h0;
  logic [23:0] ext = 24'h0, pin, oe, dv, cap, mk;
  logic [31:0] rdata, pc;
  logic        irq, pirq, compat, clk_o, clk_oe_n, clk_in;
  logic [1:0]  mode;
  logic [23:0] dout, oe_n;
  cdgcr_dma_t  dma;
  int          err_total = 0, n_compared = 0;
  logic [11:0] offs [6] = '{OFF_MASK, OFF_CTL, OFF_START, OFF_OE, OFF_INSEL, 12'h108};

  always #25 core_clk_i = ~core_clk_i;

  cdgcr_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .int_status_i(stat),
    .irq_o(irq), .port_irq_status_o(pirq), .host_chipset_compat_o(compat),
    .dma_parity_err_i(perr), .dma_fetch_advance_i(adv), .dma_ctl_o(dma),
    .dma_program_counter_o(pc), .port_function_mode_o(mode), .port_pin_data_i(pin),
    .port_pin_data_o(dout), .port_pin_data_oe_n_o(oe_n), .port_write_strobe_pin_i(strb),
    .external_irq_pin_i(xirq), .single_rate_pixel_clock_i(pclk),
    .port_clock_pin_o(clk_o), .port_clock_pin_oe_n_o(clk_oe_n),
    .pixel_clock_from_pin_o(clk_in));

  cdgcr_pin_model PINS (.ext_data_i(ext), .dut_data_i(dout), .dut_oe_n_i(oe_n), .pin_o(pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [5:0] trg(input logic [1:0] c);
    return 6'h04 << c;
  endfunction : trg

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  task automatic wrr(input logic [11:0] ad, input logic [31:0] v);
    @(negedge core_clk_i);
    wr = 1'b1;
    addr = ad;
    wdata = v;
    @(negedge core_clk_i);
    wr = 1'b0;
  endtask : wrr

  task automatic rdr(input logic [11:0] ad);
    @(negedge core_clk_i);
    rd = 1'b1;
    addr = ad;
    @(negedge core_clk_i);
    rd = 1'b0;
    rv = rdata;
  endtask : rdr

  // Bounded wait; running out goes straight to the report
  task automatic wait_pirq();
    int k;
    k = 0;
    while (pirq !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    chk("port irq status", 32'h1, {31'h0, pirq});
    if (pirq !== 1'b1) begin
      finish_test();
    end
  endtask : wait_pirq

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(10);
    rst_i = 1'b0;
    wrr(12'h108, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      rdr(offs[i]);
      chk("reset or unmapped", 32'h0, rv);
    end
    chk("oe_n reset", 32'hFFFFFF, {8'h0, oe_n});
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      stat = 23'h1 << (seed[7:0] % 23);
      seed = xs(seed);
      wrr(OFF_MASK, seed);
      chk("irq on unmask", {31'h0, |(stat & seed[22:0])}, {31'h0, irq});
      chk("compat", {31'h0, seed[23]}, {31'h0, compat});
      rdr(OFF_MASK);
      chk("mask readback", {8'h0, seed[23:0]}, rv);
      chk("irq held", {31'h0, |(stat & seed[22:0])}, {31'h0, irq});
      stat = 23'h0;
      cyc(1);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wrr(OFF_MASK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pclk = seed[31];
      // Reserved bits 9:8 kept zero, as software must
      d = {seed[31:13], i[1:0], seed[10:0]} & 32'hFFFF3CFF;
      wrr(OFF_CTL, d);
      rdr(OFF_CTL);
      chk("ctl readback", d & 32'h0000FCFF, rv);
      chk("dma ctl", {11'h0, d[1], d[0], ~d[0], trg(d[5:4]), trg(d[7:6]), trg(d[3:2])},
          {11'h0, dma});
      chk("mode", {30'h0, d[12:11]}, {30'h0, mode});
      chk("clock pin", {29'h0, pclk & d[10], ~d[10], ~d[10] & (d[12:11] == 2'h2)},
          {29'h0, clk_o, clk_oe_n, clk_in});
    end
    a = {seed[31:2], 2'b00};
    wrr(OFF_CTL, 32'h0);
    wrr(OFF_START, a);
    wrr(OFF_CTL, 32'h2);
    rdr(OFF_PC);
    chk("pc load", a, rv);
    adv = 1'b1;
    cyc(3);
    adv = 1'b0;
    rdr(OFF_PC);
    chk("pc advance", a + 32'hC, rv);
    perr = 1'b1;
    cyc(1);
    perr = 1'b0;
    chk("parity stop", 32'h0, {31'h0, dma.engine_enable});
    adv = 1'b1;
    cyc(2);
    adv = 1'b0;
    chk("pc stopped", a + 32'hC, pc);
    wrr(OFF_CTL, 32'h2);
    chk("pc reload", a, pc);
    wrr(OFF_CTL, 32'h0);
    seed = xs(seed);
    oe = seed[23:0];
    wrr(OFF_OE, {8'h0, oe});
    chk("oe_n", {8'h0, ~oe}, {8'h0, oe_n});
    seed = xs(seed);
    dv = seed[23:0];
    wrr(12'h2A4, {8'h0, dv});
    chk("pin out", {8'h0, dv}, {8'h0, dout});
    seed = xs(seed);
    ext = seed[23:0];
    cyc(6);
    rdr(OFF_DATA_HI);
    chk("direct read", {8'h0, (oe & dv) | (~oe & ext)}, rv);
    cap = ext;
    strb = 1'b1;
    cyc(6);
    ext = ~cap;
    cyc(6);
    wrr(OFF_INSEL, 32'hFFFFFF);
    rdr(OFF_DATA_LO);
    chk("rising capture", {8'h0, (oe & dv) | (~oe & cap)}, rv);
    wrr(OFF_CTL, 32'h2000);
    seed = xs(seed);
    ext = seed[23:0];
    cap = ext;
    cyc(6);
    strb = 1'b0;
    cyc(6);
    ext = ~cap;
    cyc(6);
    rdr(OFF_DATA_LO);
    chk("falling capture", {8'h0, (oe & dv) | (~oe & cap)}, rv);
    wrr(OFF_CTL, 32'h0800);
    rdr(OFF_DATA_LO);
    chk("read in pixel mode", 32'h0, rv);
    wrr(OFF_CTL, 32'h0);
    xirq = 1'b1;
    wait_pirq();
    xirq = 1'b0;
    cyc(8);
    wrr(OFF_STATUS, 32'h0);
    chk("zero keeps", 32'h1, {31'h0, pirq});
    wrr(OFF_STATUS, 32'h200);
    chk("one clears", 32'h0, {31'h0, pirq});
    wrr(OFF_CTL, 32'h4000);
    wait_pirq();
    wrr(OFF_MASK, 32'h200);
    chk("port irq request", 32'h1, {31'h0, irq});
    wrr(OFF_CTL, 32'h8000);
    cyc(8);
    wrr(OFF_STATUS, 32'h200);
    cyc(8);
    chk("edge idle", 32'h0, {31'h0, pirq});
    chk("port irq released", 32'h0, {31'h0, irq});
    xirq = 1'b1;
    wait_pirq();
    cyc(8);
    wrr(OFF_STATUS, 32'h200);
    cyc(8);
    chk("edge once", 32'h0, {31'h0, pirq});
    // Second reset mid-run: mask, control, start, enable, select, counter and request must fall back
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    chk("oe_n after reset", 32'hFFFFFF, {8'h0, oe_n});
    chk("irq after reset", 32'h0, {31'h0, irq});
    for (int i = 0; i < 5; i++) begin
      rdr(offs[i]);
      chk("defaults reloaded", 32'h0, rv);
    end
    rdr(OFF_PC);
    chk("pc after reset", 32'h0, rv);
    finish_test();
  end
endmodule : testbench
